//--- hdl/cbs_buffer_status.sv
// Buffer bookkeeping of a CAN controller: mask, full/overflow flags, pair control, events.
// Assumes the protocol engine and filters run on i_clk; message contents sit in external RAM.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cbs_map.svh"

module cbs_buffer_status (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  // AXI4-Lite write address and data
  input  wire logic                 i_s_axi_awvalid,
  output logic                      o_s_axi_awready,
  input  wire logic [`CBS_AW-1:0]   i_s_axi_awaddr,
  input  wire logic                 i_s_axi_wvalid,
  output logic                      o_s_axi_wready,
  input  wire logic [31:0]          i_s_axi_wdata,
  input  wire logic [3:0]           i_s_axi_wstrb,
  // AXI4-Lite write response
  output logic                      o_s_axi_bvalid,
  input  wire logic                 i_s_axi_bready,
  output logic [1:0]                o_s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                 i_s_axi_arvalid,
  output logic                      o_s_axi_arready,
  input  wire logic [`CBS_AW-1:0]   i_s_axi_araddr,
  output logic                      o_s_axi_rvalid,
  input  wire logic                 i_s_axi_rready,
  output logic [31:0]               o_s_axi_rdata,
  output logic [1:0]                o_s_axi_rresp,
  // Receive path from protocol engine
  input  wire logic                 i_rx_wr,
  input  wire logic [4:0]           i_rx_buf,
  input  wire logic [4:0]           i_rx_filter,
  input  wire logic                 i_remote_hit,
  input  wire logic [4:0]           i_remote_buf,
  // Transmit outcomes from protocol engine
  input  wire logic                 i_tx_ok,
  input  wire logic                 i_tx_aborted,
  input  wire logic                 i_tx_lost_arb,
  input  wire logic                 i_tx_error,
  input  wire logic [4:0]           i_tx_buf,
  // Extended identifier compare
  input  wire logic [15:0]          i_cmp_msg_eid,
  input  wire logic [15:0]          i_cmp_filter_eid,
  output logic                      o_eid_match,
  output logic [15:0]               o_eid_mask,
  // Transmit selection and abort
  output logic                      o_tx_valid,
  output logic [4:0]                o_tx_buf,
  output logic [`CBS_NBUF-1:0]      o_abort_pend,
  output logic [`CBS_NBUF-1:0]      o_tx_dir,
  // Status word write into message RAM
  output logic                      o_stat_wr,
  output logic [4:0]                o_stat_buf,
  output logic [4:0]                o_stat_code,
  // Interrupt
  output logic                      o_irq
);

  cbs_pkg::cbs_state_s state;
  cbs_pkg::cbs_state_s next_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshakes

  assign o_s_axi_awready = !state.aw_got && !state.bvalid;
  assign o_s_axi_wready  = !state.w_got && !state.bvalid;
  assign o_s_axi_arready = !state.rvalid;
  assign o_s_axi_bvalid  = state.bvalid;
  assign o_s_axi_bresp   = state.bresp;
  assign o_s_axi_rvalid  = state.rvalid;
  assign o_s_axi_rdata   = state.rdata;
  assign o_s_axi_rresp   = state.rresp;

  assign o_eid_match  = state.eid_match;
  assign o_eid_mask   = state.mask;
  assign o_tx_valid   = state.tx_valid;
  assign o_tx_buf     = state.tx_buf;
  assign o_abort_pend = state.abort_pend;
  assign o_stat_wr    = state.stat_wr;
  assign o_stat_buf   = state.stat_buf;
  assign o_stat_code  = state.stat_code;
  assign o_irq        = |(state.ev_stat & state.ev_en);

  always_comb begin
    for (int i = 0; i < `CBS_NBUF; i++) begin
      o_tx_dir[i] = state.ctrl[i][`CBS_DIR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic                 wr_go;
    logic [15:0]          wmask;
    logic [15:0]          wd;
    logic [`CBS_AW-1:0]   wa;
    logic [`CBS_AW-1:0]   ra;
    logic [3:0]           pidx;
    logic [7:0]           oldb;
    logic [7:0]           newb;
    logic                 mapped;
    logic [31:0]          rd;
    logic                 rmapped;
    logic [`CBS_NEV-1:0]  ev;
    logic [1:0]           best_pri;
    logic                 found;
    wr_go    = 1'b0;
    wmask    = 16'h0000;
    wd       = 16'h0000;
    wa       = '0;
    ra       = '0;
    pidx     = 4'h0;
    oldb     = 8'h00;
    newb     = 8'h00;
    mapped   = 1'b0;
    rd       = 32'h0000_0000;
    rmapped  = 1'b0;
    ev       = '0;
    best_pri = 2'h0;
    found    = 1'b0;
    next_state = state;
    next_state.stat_wr = 1'b0;

    // Address and data may arrive in either order
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      next_state.aw_got  = 1'b1;
      next_state.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      next_state.w_got  = 1'b1;
      next_state.w_data = i_s_axi_wdata;
      next_state.w_strb = i_s_axi_wstrb;
    end
    if (state.bvalid && i_s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    // Software write: registers hold 16 bits, lanes 0 and 1 only
    wr_go = state.aw_got && state.w_got && !state.bvalid;
    wa    = state.aw_addr;
    wd    = state.w_data[15:0];
    wmask = {{8{state.w_strb[1]}}, {8{state.w_strb[0]}}};
    if (wr_go) begin
      next_state.aw_got = 1'b0;
      next_state.w_got  = 1'b0;
      next_state.bvalid = 1'b1;
      mapped = 1'b1;
      if (wa[7:6] == `CBS_OFF_CTRL_BASE && wa[1:0] == 2'b00) begin
        pidx = wa[5:2];
        for (int h = 0; h < 2; h++) begin
          if (state.w_strb[h]) begin
            oldb = state.ctrl[{pidx, h[0]}];
            newb = wd[h*8 +: 8];
            newb[`CBS_ABT]  = oldb[`CBS_ABT];
            newb[`CBS_LARB] = oldb[`CBS_LARB];
            newb[`CBS_ERR]  = oldb[`CBS_ERR];
            if (oldb[`CBS_REQ] && !newb[`CBS_REQ]) begin
              next_state.abort_pend[{pidx, h[0]}] = 1'b1;
            end
            if (!oldb[`CBS_REQ] && newb[`CBS_REQ]) begin
              next_state.abort_pend[{pidx, h[0]}] = 1'b0;
            end
            next_state.ctrl[{pidx, h[0]}] = newb;
          end
        end
      end else begin
        case (wa)
          `CBS_OFF_MASK:
            next_state.mask = (state.mask & ~wmask) | (wd & wmask);
          // Writing one leaves a flag alone; only zero clears
          `CBS_OFF_FULL_LO: next_state.full[15:0]  = state.full[15:0] & (wd | ~wmask);
          `CBS_OFF_FULL_HI: next_state.full[31:16] = state.full[31:16] & (wd | ~wmask);
          `CBS_OFF_OVF_LO:  next_state.ovf[15:0]   = state.ovf[15:0] & (wd | ~wmask);
          `CBS_OFF_OVF_HI:  next_state.ovf[31:16]  = state.ovf[31:16] & (wd | ~wmask);
          `CBS_OFF_EV_STAT: ;
          `CBS_OFF_EV_CLR: begin
            if (state.w_strb[0]) begin
              next_state.ev_stat = state.ev_stat & ~wd[`CBS_NEV-1:0];
            end
          end
          `CBS_OFF_EV_EN: begin
            if (state.w_strb[0]) begin
              next_state.ev_en = wd[`CBS_NEV-1:0];
            end
          end
          default: mapped = 1'b0;
        endcase
      end
      next_state.bresp = mapped ? `CBS_RESP_OKAY : `CBS_RESP_SLVERR;
    end

    // Hardware events come after software so that a set wins over a clear
    if (i_rx_wr) begin
      if (state.full[i_rx_buf]) begin
        next_state.ovf[i_rx_buf] = 1'b1;
        ev[`CBS_EV_OVF] = 1'b1;
      end
      next_state.full[i_rx_buf] = 1'b1;
      ev[`CBS_EV_RXFULL] = 1'b1;
      // Status word lives in message RAM; only its write is issued here
      next_state.stat_wr   = 1'b1;
      next_state.stat_buf  = i_rx_buf;
      next_state.stat_code = i_rx_filter;
    end
    if (i_remote_hit && state.ctrl[i_remote_buf][`CBS_AUTO_REMOTE_REPLY_ENABLE]) begin
      next_state.ctrl[i_remote_buf][`CBS_REQ] = 1'b1;
      next_state.abort_pend[i_remote_buf] = 1'b0;
    end
    if (i_tx_lost_arb) begin
      next_state.ctrl[i_tx_buf][`CBS_LARB] = 1'b1;
      ev[`CBS_EV_LARB] = 1'b1;
    end
    if (i_tx_error) begin
      next_state.ctrl[i_tx_buf][`CBS_ERR] = 1'b1;
      ev[`CBS_EV_ERR] = 1'b1;
    end
    if (i_tx_aborted) begin
      next_state.ctrl[i_tx_buf][`CBS_ABT] = 1'b1;
      next_state.ctrl[i_tx_buf][`CBS_REQ] = 1'b0;
      next_state.abort_pend[i_tx_buf] = 1'b0;
      ev[`CBS_EV_ABORTED_FLAG] = 1'b1;
    end
    if (i_tx_ok) begin
      next_state.ctrl[i_tx_buf][`CBS_REQ] = 1'b0;
      next_state.ctrl[i_tx_buf][`CBS_ABT] = 1'b0;
      next_state.abort_pend[i_tx_buf] = 1'b0;
      ev[`CBS_EV_TXOK] = 1'b1;
    end

    // A rising request wipes stale outcomes, whoever raised it
    for (int i = 0; i < `CBS_NBUF; i++) begin
      if (!state.ctrl[i][`CBS_REQ] && next_state.ctrl[i][`CBS_REQ]) begin
        next_state.ctrl[i][`CBS_ABT]  = 1'b0;
        next_state.ctrl[i][`CBS_LARB] = 1'b0;
        next_state.ctrl[i][`CBS_ERR]  = 1'b0;
      end
    end
    next_state.ev_stat = next_state.ev_stat | ev;

    // Ascending scan with >= hands ties to the higher buffer number
    next_state.tx_valid = 1'b0;
    for (int i = 0; i < `CBS_NBUF; i++) begin
      if (state.ctrl[i][`CBS_DIR] && state.ctrl[i][`CBS_REQ] && !state.abort_pend[i]) begin
        if (!found || state.ctrl[i][`CBS_PRI_HI:`CBS_PRI_LO] >= best_pri) begin
          found    = 1'b1;
          best_pri = state.ctrl[i][`CBS_PRI_HI:`CBS_PRI_LO];
          next_state.tx_buf = i[4:0];
        end
      end
    end
    next_state.tx_valid = found;

    // Masked compare: zero mask bits are don't care
    next_state.eid_match = ((i_cmp_msg_eid ^ i_cmp_filter_eid) & state.mask) == 16'h0000;

    // Read: one cycle after the address is taken
    if (state.rvalid && i_s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      ra = i_s_axi_araddr;
      rmapped = 1'b1;
      if (ra[7:6] == `CBS_OFF_CTRL_BASE && ra[1:0] == 2'b00) begin
        rd = {16'h0000, state.ctrl[{ra[5:2], 1'b1}], state.ctrl[{ra[5:2], 1'b0}]};
      end else begin
        case (ra)
          `CBS_OFF_MASK:    rd = {16'h0000, state.mask};
          `CBS_OFF_FULL_LO: rd = {16'h0000, state.full[15:0]};
          `CBS_OFF_FULL_HI: rd = {16'h0000, state.full[31:16]};
          `CBS_OFF_OVF_LO:  rd = {16'h0000, state.ovf[15:0]};
          `CBS_OFF_OVF_HI:  rd = {16'h0000, state.ovf[31:16]};
          `CBS_OFF_EV_STAT: rd = {{(32-`CBS_NEV){1'b0}}, state.ev_stat};
          `CBS_OFF_EV_CLR:  rd = 32'h0000_0000;
          `CBS_OFF_EV_EN:   rd = {{(32-`CBS_NEV){1'b0}}, state.ev_en};
          default:          rmapped = 1'b0;
        endcase
      end
      next_state.rvalid = 1'b1;
      next_state.rdata  = rd;
      next_state.rresp  = rmapped ? `CBS_RESP_OKAY : `CBS_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state            <= '0;
      state.mask       <= `CBS_RST_MASK;
      state.full       <= `CBS_RST_FLAGS;
      state.ovf        <= `CBS_RST_FLAGS;
      state.ctrl       <= {`CBS_NBUF{`CBS_RST_CTRL}};
      state.abort_pend <= `CBS_RST_FLAGS;
    end else begin
      state <= next_state;
    end
  end

endmodule // cbs_buffer_status

//--- hdl/cbs_map.svh
// Register map, field positions, reset values and sizes of the CAN buffer status block.
// Assumes inclusion by the package and by the block; definitions only.
`ifndef CBS_MAP_SVH
`define CBS_MAP_SVH

`define CBS_NBUF          32
`define CBS_AW            8
// Byte addresses; the control base is the value of address bits 7:6
`define CBS_OFF_MASK      8'h00
`define CBS_OFF_FULL_LO   8'h04
`define CBS_OFF_FULL_HI   8'h08
`define CBS_OFF_OVF_LO    8'h0C
`define CBS_OFF_OVF_HI    8'h10
`define CBS_OFF_EV_STAT   8'h20
`define CBS_OFF_EV_CLR    8'h24
`define CBS_OFF_EV_EN     8'h28
`define CBS_OFF_CTRL_BASE 2'b01
// Control byte fields
`define CBS_DIR           7
`define CBS_ABT           6
`define CBS_LARB          5
`define CBS_ERR           4
`define CBS_REQ           3
`define CBS_AUTO_REMOTE_REPLY_ENABLE         2
`define CBS_PRI_HI        1
`define CBS_PRI_LO        0
// Event bits
`define CBS_EV_RXFULL     0
`define CBS_EV_OVF        1
`define CBS_EV_TXOK       2
`define CBS_EV_ABORTED_FLAG      3
`define CBS_EV_LARB       4
`define CBS_EV_ERR        5
`define CBS_NEV           6
// Reset values
`define CBS_RST_MASK      16'h0000
`define CBS_RST_FLAGS     32'h0000_0000
`define CBS_RST_CTRL      8'h00
// Bus answers
`define CBS_RESP_OKAY     2'h0
`define CBS_RESP_SLVERR   2'h2

`endif

//--- hdl/cbs_pkg.sv
// Types of the CAN buffer status block.
// Assumes cbs_map.svh on the include path.
`include "cbs_map.svh"

package cbs_pkg;

  typedef logic [`CBS_NBUF-1:0][7:0] cbs_ctrl_t;

  typedef struct packed {
    logic                  aw_got;
    logic [`CBS_AW-1:0]    aw_addr;
    logic                  w_got;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [15:0]           mask;
    logic [`CBS_NBUF-1:0]  full;
    logic [`CBS_NBUF-1:0]  ovf;
    cbs_ctrl_t             ctrl;
    logic [`CBS_NBUF-1:0]  abort_pend;
    logic [`CBS_NEV-1:0]   ev_stat;
    logic [`CBS_NEV-1:0]   ev_en;
    logic                  stat_wr;
    logic [4:0]            stat_buf;
    logic [4:0]            stat_code;
    logic                  tx_valid;
    logic [4:0]            tx_buf;
    logic                  eid_match;
  } cbs_state_s;

endpackage

//--- dv/cbs_buffer_status_asserts.sv
// Port-level checker for cbs_buffer_status.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module cbs_buffer_status_asserts (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  // Stimulus side
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_rready,
  input wire logic        i_s_axi_arvalid,
  input wire logic        i_rx_wr,
  input wire logic [4:0]  i_rx_buf,
  input wire logic [4:0]  i_rx_filter,
  input wire logic        i_tx_ok,
  input wire logic [4:0]  i_tx_buf,
  input wire logic [15:0] i_cmp_msg_eid,
  input wire logic [15:0] i_cmp_filter_eid,
  // Design outputs
  input wire logic        o_s_axi_bvalid,
  input wire logic        o_s_axi_rvalid,
  input wire logic        o_s_axi_arready,
  input wire logic        o_eid_match,
  input wire logic [15:0] o_eid_mask,
  input wire logic        o_tx_valid,
  input wire logic [4:0]  o_tx_buf,
  input wire logic [31:0] o_abort_pend,
  input wire logic [31:0] o_tx_dir,
  input wire logic        o_stat_wr,
  input wire logic [4:0]  o_stat_buf,
  input wire logic [4:0]  o_stat_code
);
  logic [31:0] dir_q;
  logic [31:0] pend_q;
  // Selection lags the control state by one cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dir_q  <= 32'h0;
      pend_q <= 32'h0;
    end else begin
      dir_q  <= o_tx_dir;
      pend_q <= o_abort_pend;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_stat_wr;
    i_rx_wr |=> o_stat_wr && o_stat_buf == $past(i_rx_buf) && o_stat_code == $past(i_rx_filter);
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status write wrong");
  property p_stat_cause;
    o_stat_wr |-> $past(i_rx_wr);
  endproperty
  a_stat_cause: assert property (p_stat_cause) else $error("stray status write");
  // Release edge excluded: the block still sits in reset there
  property p_eid;
    i_arst_n |=> o_eid_match == ((($past(i_cmp_msg_eid) ^ $past(i_cmp_filter_eid))
      & $past(o_eid_mask)) == 16'h0000);
  endproperty
  a_eid: assert property (p_eid) else $error("masked compare wrong");
  property p_sel_dir;
    o_tx_valid |-> dir_q[o_tx_buf];
  endproperty
  a_sel_dir: assert property (p_sel_dir) else $error("receive buffer offered");
  property p_sel_abort;
    o_tx_valid |-> !pend_q[o_tx_buf];
  endproperty
  a_sel_abort: assert property (p_sel_abort) else $error("aborted buffer offered");
  property p_ok_clears;
    i_tx_ok |=> !o_abort_pend[$past(i_tx_buf)];
  endproperty
  a_ok_clears: assert property (p_ok_clears) else $error("abort kept after send");
  property p_b_once;
    o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
  property p_r_once;
    o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once) else $error("read answer repeated");
  property p_arready;
    $rose(o_s_axi_rvalid) |-> $past(i_s_axi_arvalid) && $past(o_s_axi_arready);
  endproperty
  a_arready: assert property (p_arready) else $error("read answer without request");
endmodule // cbs_buffer_status_asserts

bind cbs_buffer_status cbs_buffer_status_asserts cbs_buffer_status_asserts_inst (.*);

//--- dv/cbs_engine_model.sv
// Protocol engine stand-in reporting transmit outcomes.
// Assumes the bench pulses i_fire for one cycle with kind, buffer and delay.
`timescale 1ns/1ps
module cbs_engine_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // Bench command
  input  wire logic       i_fire,
  input  wire logic [3:0] i_kind,
  input  wire logic [4:0] i_buf,
  input  wire logic [3:0] i_dly,
  // Outcome toward the block
  output logic [3:0]      o_evt,
  output logic [4:0]      o_buf
);
  logic [3:0] cnt;
  logic [3:0] kind;
  logic [4:0] buf_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt   <= 4'h0;
      kind  <= 4'h0;
      buf_q <= 5'h00;
    end else if (i_fire) begin
      cnt   <= i_dly;
      kind  <= i_kind;
      buf_q <= i_buf;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  // One-cycle outcome: error, lost arb, aborted, success
  assign o_evt = (cnt == 4'h1) ? kind : 4'h0;
  // Buffer number is meaningless outside the pulse
  assign o_buf = (cnt == 4'h1) ? buf_q : ~buf_q;
endmodule // cbs_engine_model

//--- dv/tb_top.sv
// Self-checking bench for cbs_buffer_status.
// Assumes the engine model file and the checker bind are compiled alongside.
`timescale 1ns/1ps
`include "cbs_map.svh"
module tb_top;
  typedef struct packed {logic [7:0] a; logic [15:0] w, e; logic [1:0] r;} cbs_row_s;
  logic        i_clk = 1'h0, i_arst_n = 1'h0;
  logic        i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
  logic        i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
  logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata;
  logic [3:0]  i_s_axi_wstrb = 4'h0;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, r;
  logic        i_rx_wr = 1'h0, i_remote_hit = 1'h0, i_tx_ok, i_tx_aborted, i_tx_lost_arb, i_tx_error;
  logic [4:0]  i_rx_buf = 5'h00, i_rx_filter = 5'h00, i_remote_buf = 5'h00, i_tx_buf;
  logic [15:0] i_cmp_msg_eid = 16'h0, i_cmp_filter_eid = 16'h0, o_eid_mask;
  logic        o_eid_match, o_tx_valid, o_stat_wr, o_irq, fire = 1'h0;
  logic [4:0]  o_tx_buf, o_stat_buf, o_stat_code, pbuf = 5'h00;
  logic [31:0] o_abort_pend, o_tx_dir, d;
  logic [3:0]  kind = 4'h0, dly = 4'h1;
  int          failures = 0, checked = 0, cyc = 0;
  cbs_row_s    rows [9] = '{
    '{8'h00, 16'hA5C3, 16'hA5C3, 2'h0}, '{8'h04, 16'hFFFF, 16'h0000, 2'h0},
    '{8'h10, 16'hFFFF, 16'h0000, 2'h0}, '{8'h44, 16'hFFFF, 16'h8F8F, 2'h0},
    '{8'h20, 16'h003F, 16'h0000, 2'h0}, '{8'h28, 16'h003F, 16'h003F, 2'h0},
    '{8'h30, 16'h1234, 16'h0000, 2'h2}, '{8'h0C, 16'hFFFF, 16'h0000, 2'h0},
    '{8'h24, 16'h0000, 16'h0000, 2'h0}};
  cbs_buffer_status cbs_buffer_status_inst (.*);
  cbs_engine_model cbs_engine_model_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_fire(fire),
    .i_kind(kind), .i_buf(pbuf), .i_dly(dly), .o_buf(i_tx_buf),
    .o_evt({i_tx_error, i_tx_lost_arb, i_tx_aborted, i_tx_ok}));
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      $display("MISMATCH %0t run too long", $time);
      finish_test();
    end
  end
  task automatic finish_test;
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_clk);
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= {16'h0, v};
    i_s_axi_wstrb <= 4'hF;
    // No cycle limit here: only the bench timeout ends a hung wait
    do begin
      @(posedge i_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
    end while (!o_s_axi_bvalid);
    r = o_s_axi_bresp;
    i_s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    {i_s_axi_arvalid, i_s_axi_rready} <= 2'h3;
    i_s_axi_araddr <= a;
    do begin
      @(posedge i_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
    end while (!o_s_axi_rvalid);
    d = o_s_axi_rdata;
    r = o_s_axi_rresp;
    i_s_axi_rready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk(d, {16'h0, e});
  endtask
  task automatic rx(input logic [4:0] b, input logic [4:0] f);
    @(posedge i_clk);
    {i_rx_wr, i_rx_buf, i_rx_filter} <= {1'h1, b, f};
    @(posedge i_clk);
    i_rx_wr <= 1'h0;
  endtask
  task automatic eng(input logic [3:0] k, input logic [4:0] b, input logic [3:0] t);
    @(posedge i_clk);
    {fire, kind, pbuf, dly} <= {1'h1, k, b, t};
    @(posedge i_clk);
    fire <= 1'h0;
    repeat (t + 2) @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'h1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk(r, rows[i].r);
      rd(rows[i].a);
      chk(d, {16'h0, rows[i].e});
      chk(r, rows[i].r);
    end
    // Equal priority on 2 and 3, then 4 at top priority beats 5 and the rest
    chk(o_tx_buf, 5'h03);
    chk(o_tx_valid, 1'h1);
    wr(8'h48, 16'h8A8B);
    repeat (2) @(posedge i_clk);
    chk(o_tx_buf, 5'h04);
    wr(8'h44, 16'h0000);
    chk(o_abort_pend[3:2], 2'h3);
    eng(4'h1, 5'h04, 4'h3);
    rc(8'h48, 16'h8A83);
    chk(o_irq, 1'h1);
    eng(4'h2, 5'h03, 4'h1);
    chk(o_abort_pend[3], 1'h0);
    eng(4'hC, 5'h02, 4'h2);
    rc(8'h44, 16'h4030);
    wr(8'h44, 16'h4008);
    rc(8'h44, 16'h4008);
    // Receive side: full, overflow, clear-only
    rx(5'h11, 5'h09);
    rc(8'h08, 16'h0002);
    rx(5'h11, 5'h1E);
    rc(8'h10, 16'h0002);
    wr(8'h08, 16'hFFFF);
    rc(8'h08, 16'h0002);
    wr(8'h08, 16'hFFFD);
    rc(8'h08, 16'h0000);
    rc(8'h10, 16'h0002);
    wr(8'h10, 16'h0000);
    rc(8'h10, 16'h0000);
    // Interrupt: clear, mask, event, unmask
    wr(8'h24, 16'h003F);
    wr(8'h28, 16'h0000);
    rx(5'h00, 5'h01);
    chk(o_irq, 1'h0);
    rc(8'h20, 16'h0001);
    wr(8'h28, 16'h0001);
    chk(o_irq, 1'h1);
    // Remote frames with and without auto reply
    wr(8'h4C, 16'h0004);
    @(posedge i_clk);
    {i_remote_hit, i_remote_buf} <= {1'h1, 5'h06};
    @(posedge i_clk);
    i_remote_buf <= 5'h07;
    @(posedge i_clk);
    i_remote_hit <= 1'h0;
    rc(8'h4C, 16'h000C);
    // Masked identifier compare
    i_cmp_filter_eid <= 16'h5A3C;
    repeat (2) @(posedge i_clk);
    chk(o_eid_match, 1'h1);
    chk(o_eid_mask, 16'hA5C3);
    i_cmp_filter_eid <= 16'h0001;
    repeat (2) @(posedge i_clk);
    chk(o_eid_match, 1'h0);
    // Reset in mid-run
    i_arst_n <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'h1;
    chk(o_tx_dir, 32'h0);
    chk(o_tx_valid, 1'h0);
    chk(o_eid_mask, 16'h0000);
    chk(o_irq, 1'h0);
    rc(8'h44, 16'h0000);
    rc(8'h04, 16'h0000);
    finish_test();
  end
endmodule // tb_top
